// >>> hdl/emap_top.sv
// Purpose: Address generation, internal memory map and bus pin drive
// Assumes: APB and core requests share pclk; one wait state on APB
// Notes: Strobe timing and data transfer live outside this block
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
//Operation
// - Scratchpad and 4kB SRAM for data/stack/code
// - 4MB outside memory, 20-bit bus, selects
// - Address mode field picks one of three
// - 16-bit mode limits to 64kB, reset default
// - Paged mode adds cycle on calls, returns
// - Paged mode vectors fetched with zero page
// - Contiguous mode uses full 22-bit counter
// - Contiguous mode pointer increment one cycle longer
// - 23rd bit maps SRAM above 4MB
// - First pointer moves use extension, high, low
// - Second pointer moves use its three bytes
// - Indirect moves use extension, port latch, register
// - Paged fetch takes upper bits from page
// - Extended stack joins high and low pointers
// - Stack extend reserves lowest 1kB of SRAM
// - Internal accesses raise no pin strobes
// - Map field places SRAM at chosen window
// - CAN map bit places message area
// - No extended stack in shared mode
// - Reset drives address lines, chip selects, fetch zero
// - Bus signals placed on port pins; mux bit moves low address from port 1 to port 0
// - Port field codes 100 to 111 enable one to four pins
module emap_top
    import emap_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic acc_req,
    input wire logic [2:0] acc_kind,
    input wire logic acc_write,
    input wire logic [21:0] acc_pc,
    input wire logic [7:0] acc_ri,
    input wire logic acc_vector,
    input wire logic op_call_ret,
    input wire logic op_inc_first_data_pointer,
    input wire logic irq_ack,
    output logic [23:0] full_addr,
    output logic int_sram_sel,
    output logic can_sel,
    output logic extra_cycle,
    output logic [7:0] p4_out,
    output logic [7:0] p4_oe,
    output logic [7:0] p2_out,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe,
    output logic [3:0] pce_n,
    output logic rd_n,
    output logic wr_n,
    output logic program_fetch_strobe_n
);

    // Pin mask for a port-4 field code
    function automatic logic [3:0] pin_mask(input logic [2:0] code);
        unique case (code)
            3'h4: pin_mask = 4'h1;
            3'h5: pin_mask = 4'h3;
            3'h6: pin_mask = 4'h7;
            3'h7: pin_mask = 4'hF;
            default: pin_mask = 4'h0;
        endcase
    endfunction

    function automatic logic in_rng(input logic [23:0] a, input logic [23:0] b,
                                    input logic [23:0] n);
        in_rng = (a >= b) && ((a - b) < n);
    endfunction

    function automatic logic [23:0] actl_can_base(input logic hi);
        actl_can_base = hi ? CAN_HI_BASE : CAN_LO_BASE;
    endfunction

    logic [7:0] sp_r, dpl0_r, dph0_r, ptr1_lo_r, ptr1_hi_r, p4ctl_r, dpx0_r;
    logic [7:0] ptr1_ext_r, sph_r, page_r, actl_r, p2_r, mctl_r, mxx_r;
    logic conflict_r;
    logic apb_do;
    logic [7:0] ix;
    logic hit;
    logic [7:0] rsel;
    emap_mode_type mode;
    logic [1:0] idm;
    logic sa_eff;
    logic [23:0] sram_base;
    logic [23:0] a_nxt;
    logic is_fetch;
    logic sram_hit;
    logic can_hit;
    logic internal;
    logic stack_clash;
    logic [3:0] hi_mask;
    logic [3:0] lo_mask;

    assign ix = paddr[9:2];
    assign apb_do = psel && penable && pready;
    assign idm = mctl_r[MCTL_IDM +: 2];
    assign sa_eff = actl_r[ACTL_SA] && (idm != IDM_SHARED);
    assign hi_mask = pin_mask(p4ctl_r[P4_HI +: 3]);
    assign lo_mask = pin_mask(p4ctl_r[P4_LO +: 3]);
    assign is_fetch = (acc_kind == K_FETCH);

    // Mode decode; reserved code behaves as 16-bit
    always_comb begin
        unique case (actl_r[ACTL_AM +: 2])
            2'h1: mode = EM_PAGED;
            2'h2: mode = EM_CONTIG;
            default: mode = EM_M16;
        endcase
    end

    // Register decode and read mux
    always_comb begin
        hit = 1'b1;
        rsel = RST_ZERO;
        unique case (ix)
            IX_SP: rsel = sp_r;
            IX_DPL0: rsel = dpl0_r;
            IX_DPH0: rsel = dph0_r;
            IX_PTR1_LO: rsel = ptr1_lo_r;
            IX_PTR1_HI: rsel = ptr1_hi_r;
            IX_P4CTL: rsel = p4ctl_r;
            IX_DPX0: rsel = dpx0_r;
            IX_PTR1_EXT: rsel = ptr1_ext_r;
            IX_SPH: rsel = sph_r;
            IX_PAGE: rsel = page_r;
            IX_ACTL: rsel = actl_r;
            IX_STAT: rsel = {5'h00, sa_eff, idm == IDM_SHARED, conflict_r};
            IX_P2: rsel = p2_r;
            IX_MCTL: rsel = mctl_r;
            IX_MXX: rsel = mxx_r;
            default: hit = 1'b0;
        endcase
        if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end
    end

    // SRAM window per map field
    always_comb begin
        unique case (idm)
            2'h0: sram_base = SRAM_HI_BASE;
            2'h1: sram_base = SRAM_LO_BASE;
            default: sram_base = SRAM_EXT_BASE;
        endcase
    end

    // Address formation per access kind
    always_comb begin
        a_nxt = 24'h000000;
        unique case (acc_kind)
            K_FETCH: begin
                unique case (mode)
                    EM_M16: a_nxt = {8'h00, acc_pc[15:0]};
                    EM_PAGED: a_nxt = acc_vector ? {8'h00, acc_pc[15:0]}
                                                 : {page_r, acc_pc[15:0]};
                    EM_CONTIG: a_nxt = {2'h0, acc_pc};
                endcase
            end
            K_DPTR0: a_nxt = {dpx0_r, dph0_r, dpl0_r};
            K_SECOND_DATA_POINTER: a_nxt = {ptr1_ext_r, ptr1_hi_r, ptr1_lo_r};
            K_RI: a_nxt = {mxx_r, p2_r, acc_ri};
            K_STACK: a_nxt = sram_base + {14'h0000, sph_r[1:0], sp_r};
            default: a_nxt = 24'h000000;
        endcase
        if (mode == EM_M16 && acc_kind != K_STACK) begin
            a_nxt[23:16] = 8'h00;
        end
    end

    // Internal decode: SRAM, CAN area, scratchpad stack
    always_comb begin
        if (is_fetch) begin
            sram_hit = (idm == IDM_SHARED) && in_rng(a_nxt, SRAM_EXT_BASE, SRAM_SIZE);
            can_hit = 1'b0;
        end else begin
            sram_hit = in_rng(a_nxt, sram_base, SRAM_SIZE) || (acc_kind == K_STACK);
            can_hit = in_rng(a_nxt, actl_can_base(mctl_r[MCTL_CMA]), CAN_SIZE);
        end
        internal = sram_hit || can_hit;
        stack_clash = sa_eff && !is_fetch && acc_kind != K_STACK
                      && in_rng(a_nxt, sram_base, STACK_SIZE);
    end

    // APB handshake with one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            if (psel && penable && !pready) begin
                prdata <= {24'h000000, rsel};
            end
        end
    end

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_r <= RST_ZERO;
            dpl0_r <= RST_ZERO;
            dph0_r <= RST_ZERO;
            ptr1_lo_r <= RST_ZERO;
            ptr1_hi_r <= RST_ZERO;
            p4ctl_r <= RST_P4CTL;
            dpx0_r <= RST_ZERO;
            ptr1_ext_r <= RST_ZERO;
            sph_r <= RST_ZERO;
            page_r <= RST_ZERO;
            actl_r <= RST_ZERO;
            p2_r <= RST_ZERO;
            mctl_r <= RST_ZERO;
            mxx_r <= RST_ZERO;
        end else if (apb_do && pwrite && hit) begin
            unique case (ix)
                IX_SP: sp_r <= pwdata[7:0];
                IX_DPL0: dpl0_r <= pwdata[7:0];
                IX_DPH0: dph0_r <= pwdata[7:0];
                IX_PTR1_LO: ptr1_lo_r <= pwdata[7:0];
                IX_PTR1_HI: ptr1_hi_r <= pwdata[7:0];
                IX_P4CTL: p4ctl_r <= {2'h0, pwdata[5:0]};
                IX_DPX0: dpx0_r <= pwdata[7:0];
                IX_PTR1_EXT: ptr1_ext_r <= pwdata[7:0];
                IX_SPH: sph_r <= pwdata[7:0];
                IX_PAGE: page_r <= pwdata[7:0];
                IX_ACTL: begin
                    actl_r <= {4'h0, pwdata[3:0]};
                    actl_r[ACTL_SA] <= pwdata[ACTL_SA] && (idm != IDM_SHARED);
                end
                IX_P2: p2_r <= pwdata[7:0];
                IX_MCTL: begin
                    mctl_r <= {pwdata[7:5], 5'h00};
                    if (pwdata[MCTL_IDM +: 2] == IDM_SHARED) begin
                        actl_r[ACTL_SA] <= 1'b0;
                    end
                end
                IX_MXX: mxx_r <= pwdata[7:0];
                default: mxx_r <= mxx_r;
            endcase
        end
    end

    // Sticky stack clash flag, write one clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conflict_r <= 1'b0;
        end else if (acc_req && stack_clash) begin
            conflict_r <= 1'b1;
        end else if (apb_do && pwrite && ix == IX_STAT && pwdata[0]) begin
            conflict_r <= 1'b0;
        end
    end

    // Extra machine cycle indication
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extra_cycle <= 1'b0;
        end else begin
            extra_cycle <= (mode == EM_PAGED && (op_call_ret || irq_ack))
                           || (mode == EM_CONTIG && op_inc_first_data_pointer);
        end
    end

    // Access result and strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_addr <= 24'h000000;
            int_sram_sel <= 1'b0;
            can_sel <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            program_fetch_strobe_n <= 1'b1;
            pce_n <= 4'hF;
        end else begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            program_fetch_strobe_n <= 1'b1;
            pce_n <= 4'hF;
            int_sram_sel <= 1'b0;
            can_sel <= 1'b0;
            if (acc_req) begin
                full_addr <= a_nxt;
                int_sram_sel <= sram_hit || stack_clash;
                can_sel <= can_hit && !stack_clash;
                if (!internal && !stack_clash) begin
                    program_fetch_strobe_n <= !is_fetch;
                    rd_n <= is_fetch || acc_write;
                    wr_n <= is_fetch || !acc_write;
                    if (!is_fetch) begin
                        pce_n <= ~(4'h1 << a_nxt[21:20]);
                    end
                end
            end
        end
    end

    // Port pin drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p4_out <= 8'h0F;
            p4_oe <= 8'hFF;
            p2_out <= 8'h00;
            p0_out <= 8'h00;
            p0_oe <= 8'h00;
            p1_out <= 8'h00;
            p1_oe <= 8'h00;
        end else begin
            p4_oe <= {hi_mask, lo_mask};
            p4_out[3:0] <= 4'hF;
            p0_oe <= 8'h00;
            p1_oe <= actl_r[ACTL_MUX] ? 8'h00 : 8'hFF;
            if (acc_req && !internal && !stack_clash) begin
                p4_out[7:4] <= a_nxt[19:16];
                p2_out <= a_nxt[15:8];
                if (is_fetch) begin
                    p4_out[3:0] <= ~(4'h1 << a_nxt[21:20]);
                end
                if (actl_r[ACTL_MUX]) begin
                    p0_out <= a_nxt[7:0];
                    p0_oe <= 8'hFF;
                end else begin
                    p1_out <= a_nxt[7:0];
                end
            end
        end
    end

    sequence s_fetch_paged;
        acc_req && is_fetch && mode == EM_PAGED;
    endsequence

    sequence s_strobe_quiet;
        rd_n && wr_n && program_fetch_strobe_n;
    endsequence

    int_nostrobe_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_req && internal |=> s_strobe_quiet)
        else $error("strobe on internal access");

    sa_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_do && pwrite && ix == IX_ACTL && idm == IDM_SHARED |=> !actl_r[ACTL_SA])
        else $error("stack extend accepted in shared mode");

    paged_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_fetch_paged ##0 acc_vector |=> full_addr[23:16] == 8'h00)
        else $error("vector fetch off page zero");

    paged_page_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_fetch_paged ##0 !acc_vector |=> full_addr[23:16] == $past(page_r))
        else $error("paged fetch page bits wrong");

    dptr0_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_req && acc_kind == K_DPTR0 && mode != EM_M16
        |=> full_addr == {$past(dpx0_r), $past(dph0_r), $past(dpl0_r)})
        else $error("first pointer address wrong");

    call_extra_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == EM_PAGED && op_call_ret |=> extra_cycle)
        else $error("no extra cycle on paged call");

    inc_extra_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode == EM_CONTIG && op_inc_first_data_pointer |=> extra_cycle)
        else $error("no extra cycle on pointer increment");

    fetch_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc_req && is_fetch && mode == EM_M16
        |=> full_addr[23:16] == 8'h00 && !program_fetch_strobe_n)
        else $error("16-bit fetch beyond 64kB");

    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb ready not one cycle");

endmodule // emap_top

// >>> inc/emap_pkg.sv
// Purpose: Constants for the external memory address map block
// Assumes: APB word index equals the printed register offset
// Notes: Byte address of a register is four times its index
package emap_pkg;
    localparam logic [7:0] IX_SP = 8'h81;
    localparam logic [7:0] IX_DPL0 = 8'h82;
    localparam logic [7:0] IX_DPH0 = 8'h83;
    localparam logic [7:0] IX_PTR1_LO = 8'h84;
    localparam logic [7:0] IX_PTR1_HI = 8'h85;
    localparam logic [7:0] IX_P4CTL = 8'h92;
    localparam logic [7:0] IX_DPX0 = 8'h93;
    localparam logic [7:0] IX_PTR1_EXT = 8'h95;
    localparam logic [7:0] IX_SPH = 8'h9B;
    localparam logic [7:0] IX_PAGE = 8'h9C;
    localparam logic [7:0] IX_ACTL = 8'h9E;
    localparam logic [7:0] IX_STAT = 8'h9F;
    localparam logic [7:0] IX_P2 = 8'hA0;
    localparam logic [7:0] IX_MCTL = 8'hC6;
    localparam logic [7:0] IX_MXX = 8'hEA;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_P4CTL = 8'h3F;
    localparam int ACTL_AM = 0;
    localparam int ACTL_SA = 2;
    localparam int ACTL_MUX = 3;
    localparam int MCTL_CMA = 5;
    localparam int MCTL_IDM = 6;
    localparam int P4_HI = 3;
    localparam int P4_LO = 0;
    localparam logic [1:0] IDM_SHARED = 2'h3;
    localparam logic [23:0] SRAM_HI_BASE = 24'h00F000;
    localparam logic [23:0] SRAM_LO_BASE = 24'h000000;
    localparam logic [23:0] SRAM_EXT_BASE = 24'h400000;
    localparam logic [23:0] SRAM_SIZE = 24'h001000;
    localparam logic [23:0] CAN_LO_BASE = 24'h00EE00;
    localparam logic [23:0] CAN_HI_BASE = 24'h401000;
    localparam logic [23:0] CAN_SIZE = 24'h000200;
    localparam logic [23:0] STACK_SIZE = 24'h000400;
    localparam logic [2:0] K_FETCH = 3'h0;
    localparam logic [2:0] K_DPTR0 = 3'h1;
    localparam logic [2:0] K_SECOND_DATA_POINTER = 3'h2;
    localparam logic [2:0] K_RI = 3'h3;
    localparam logic [2:0] K_STACK = 3'h4;
    typedef enum logic [1:0] {EM_M16, EM_PAGED, EM_CONTIG} emap_mode_type;
endpackage

// >>> test/emap_mem_model.sv
// Purpose: Passive model of the outside program and data memory
// Assumes: Pins settle one cycle after an access request
// Notes: Latches the address seen on the pins while a strobe is low
`timescale 1ns/10ps
module emap_mem_model (
    input wire logic pclk,
    input wire logic [7:0] p4_out,
    input wire logic [7:0] p2_out,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p0_oe,
    input wire logic [7:0] p1_out,
    input wire logic [3:0] pce_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic program_fetch_strobe_n,
    output logic [19:0] mem_addr,
    output logic [3:0] mem_sel_n
);
    initial begin
        mem_addr = 20'h00000;
        mem_sel_n = 4'hF;
    end

    // Mid-cycle capture, pins stable by then
    always @(negedge pclk) begin
        if (!rd_n || !wr_n || !program_fetch_strobe_n) begin
            mem_addr <= {p4_out[7:4], p2_out, (p0_oe != 8'h00) ? p0_out : p1_out};
            mem_sel_n <= program_fetch_strobe_n ? pce_n : p4_out[3:0];
        end
    end
endmodule // emap_mem_model

// >>> test/emap_top_tb.sv
// Purpose: Self-checking bench for the address map block
// Assumes: One APB wait state, access answers one cycle after request
// Notes: Random pointer traffic mixed with boundary addresses
`timescale 1ns/10ps
module emap_top_tb;
    import emap_pkg::*;
    localparam logic [7:0] IXT [9] = '{IX_DPX0, IX_DPH0, IX_DPL0, IX_PTR1_EXT, IX_PTR1_HI,
        IX_PTR1_LO, IX_MXX, IX_P2, IX_P2};
    localparam logic [7:0] RIX [15] = '{IX_SP, IX_DPL0, IX_DPH0, IX_PTR1_LO, IX_PTR1_HI,
        IX_P4CTL, IX_DPX0, IX_PTR1_EXT, IX_SPH, IX_PAGE, IX_ACTL, IX_STAT, IX_P2, IX_MCTL,
        IX_MXX};
    localparam logic [23:0] CRN [5] = '{24'h00EDFF, 24'h00EE00, 24'h00EFFF, 24'h00FFFF,
        24'h010000};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic acc_req, acc_write, acc_vector, op_call_ret, op_inc_first_data_pointer, irq_ack, rerr;
    logic [2:0] acc_kind, k;
    logic [21:0] acc_pc, pc;
    logic [7:0] acc_ri, p4_out, p4_oe, p2_out, p0_out, p0_oe, p1_out, p1_oe, b0;
    logic [23:0] full_addr, ea;
    logic int_sram_sel, can_sel, extra_cycle, rd_n, wr_n, program_fetch_strobe_n;
    logic [3:0] pce_n, mem_sel_n;
    logic [19:0] mem_addr;
    int errors, comparisons, cycles;

    emap_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc_req(acc_req), .acc_kind(acc_kind), .acc_write(acc_write),
        .acc_pc(acc_pc), .acc_ri(acc_ri), .acc_vector(acc_vector), .op_call_ret(op_call_ret),
        .op_inc_first_data_pointer(op_inc_first_data_pointer), .irq_ack(irq_ack), .full_addr(full_addr),
        .int_sram_sel(int_sram_sel), .can_sel(can_sel), .extra_cycle(extra_cycle),
        .p4_out(p4_out), .p4_oe(p4_oe), .p2_out(p2_out), .p0_out(p0_out), .p0_oe(p0_oe),
        .p1_out(p1_out), .p1_oe(p1_oe), .pce_n(pce_n), .rd_n(rd_n), .wr_n(wr_n),
        .program_fetch_strobe_n(program_fetch_strobe_n));

    emap_mem_model i_mem (.pclk(pclk), .p4_out(p4_out), .p2_out(p2_out), .p0_out(p0_out),
        .p0_oe(p0_oe), .p1_out(p1_out), .pce_n(pce_n), .rd_n(rd_n), .wr_n(wr_n),
        .program_fetch_strobe_n(program_fetch_strobe_n), .mem_addr(mem_addr),
        .mem_sel_n(mem_sel_n));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] ix, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, ix, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic acc(input logic [2:0] kd, input logic w, input logic [21:0] p,
        input logic [7:0] ri, input logic v);
        @(posedge pclk);
        acc_req <= 1'b1;
        acc_kind <= kd;
        acc_write <= w;
        acc_pc <= p;
        acc_ri <= ri;
        acc_vector <= v;
        @(posedge pclk);
        acc_req <= 1'b0;
        #1;
    endtask

    function automatic logic [1:0] hit(input logic [23:0] a, input logic [1:0] m,
        input logic c);
        logic [23:0] sb;
        logic [23:0] cb;
        sb = (m == 2'h0) ? SRAM_HI_BASE : (m == 2'h1) ? SRAM_LO_BASE : SRAM_EXT_BASE;
        cb = c ? CAN_HI_BASE : CAN_LO_BASE;
        return {a >= cb && a < cb + CAN_SIZE, a >= sb && a < sb + SRAM_SIZE};
    endfunction

    // One-hot active-low select from address bits 21:20
    function automatic logic [3:0] sel_exp(input logic [1:0] s);
        sel_exp = ~(4'h1 << s);
    endfunction

    task automatic set_ptr(input logic [2:0] kd, input logic [23:0] a);
        for (int j = 0; j < ((kd == K_RI) ? 2 : 3); j++) begin
            apb(1'b1, IXT[3 * (kd - 1) + j], a[23 - 8 * j -: 8]);
        end
    endtask

    task automatic data_chk(input logic [2:0] kd, input logic [23:0] a, input logic [1:0] m,
        input logic c);
        logic [1:0] h;
        logic w;
        h = hit(a, m, c);
        w = 1'($urandom);
        acc(kd, w, 22'h000000, a[7:0], 1'b0);
        chk(32'(full_addr), 32'(a), "data address");
        chk(32'({can_sel, int_sram_sel}), 32'(h), "internal hit");
        chk(32'(rd_n), 32'(w || h != 2'h0), "read strobe");
        chk(32'(wr_n), 32'(!w || h != 2'h0), "write strobe");
        chk(32'(pce_n), 32'((h != 2'h0) ? 4'hF : sel_exp(a[21:20])), "select");
        if (h == 2'h0) begin
            @(negedge pclk);
            #1;
            chk(32'(mem_addr), 32'(a[19:0]), "pin address");
            chk(32'(mem_sel_n), 32'(sel_exp(a[21:20])), "pin select");
        end
    endtask

    task automatic fetch_chk(input logic [21:0] p, input logic v, input logic [23:0] a);
        acc(K_FETCH, 1'b0, p, 8'h00, v);
        chk(32'(full_addr), 32'(a), "fetch address");
        chk(32'(program_fetch_strobe_n), 32'h0, "fetch strobe");
        chk(32'(p4_out[3:0]), 32'(sel_exp(a[21:20])), "chip select");
        @(negedge pclk);
        #1;
        chk(32'(mem_addr), 32'(a[19:0]), "pin address");
        chk(32'(mem_sel_n), 32'(sel_exp(a[21:20])), "pin chip select");
    endtask

    initial begin
        {psel, penable, pwrite, acc_req, acc_write, acc_vector} = 6'h00;
        {op_call_ret, op_inc_first_data_pointer, irq_ack} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        acc_kind = 3'h0;
        acc_pc = 22'h000000;
        acc_ri = 8'h00;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        presetn = 1'b0;
        void'($urandom(8580));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(p4_oe), 32'hFF, "port4 enables");
        chk(32'(p4_out), 32'h0F, "port4 idle");
        fetch_chk(22'h000000, 1'b0, 24'h000000);
        chk(32'(p1_oe), 32'hFF, "port1 drive");
        foreach (RIX[i]) begin
            apb(1'b0, RIX[i], 8'h00);
            chk(rdat, 32'((RIX[i] == IX_P4CTL) ? RST_P4CTL : RST_ZERO), "reset");
            if (!(RIX[i] inside {IX_P4CTL, IX_ACTL, IX_MCTL, IX_STAT})) begin
                b0 = 8'($urandom);
                apb(1'b1, RIX[i], b0);
                apb(1'b0, RIX[i], 8'h00);
                chk(rdat, 32'(b0), "read back");
            end
        end
        apb(1'b1, 8'h80, 8'h55);
        chk(32'(rerr), 32'h1, "unmapped write");
        apb(1'b0, 8'h80, 8'h00);
        chk({rdat[30:0], rerr}, 32'h1, "unmapped read");
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, IX_ACTL, 8'(m));
            b0 = 8'($urandom % 64);
            apb(1'b1, IX_PAGE, b0);
            pc = 22'($urandom);
            ea = (m == 0) ? {8'h00, pc[15:0]} : (m == 1) ? {b0, pc[15:0]} : {2'b00, pc};
            fetch_chk(pc, 1'b0, ea);
            if (m == 1) fetch_chk(pc, 1'b1, {8'h00, pc[15:0]});
        end
        apb(1'b1, IX_ACTL, 8'h02);
        for (int i = 0; i < 24; i++) begin
            k = 3'(1 + $urandom % 3);
            ea = (i < 5) ? CRN[i] : {2'b00, 22'($urandom)};
            set_ptr(k, ea);
            data_chk(k, ea, 2'h0, 1'b0);
        end
        apb(1'b1, IX_ACTL, 8'h0A);
        set_ptr(K_SECOND_DATA_POINTER, 24'h12A5C3);
        chk(32'(p1_oe), 32'h00, "port1 released");
        data_chk(K_SECOND_DATA_POINTER, 24'h12A5C3, 2'h0, 1'b0);
        apb(1'b1, IX_ACTL, 8'h00);
        set_ptr(K_SECOND_DATA_POINTER, 24'h3A1234);
        data_chk(K_SECOND_DATA_POINTER, 24'h001234, 2'h0, 1'b0);
        apb(1'b1, IX_ACTL, 8'h02);
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, IX_MCTL, {m[2:1], m[0], 5'h00});
            ea = (m < 2) ? 24'h00F010 : (m < 4) ? 24'h000010 : 24'h400010;
            set_ptr(K_DPTR0, ea);
            data_chk(K_DPTR0, ea, 2'(m >> 1), m[0]);
            ea = m[0] ? 24'h401004 : 24'h00EE04;
            set_ptr(K_DPTR0, ea);
            data_chk(K_DPTR0, ea, 2'(m >> 1), m[0]);
        end
        apb(1'b1, IX_MCTL, 8'h00);
        apb(1'b1, IX_ACTL, 8'h06);
        apb(1'b1, IX_SPH, 8'h02);
        apb(1'b1, IX_SP, 8'h34);
        acc(K_STACK, 1'b1, 22'h000000, 8'h00, 1'b0);
        chk(32'(full_addr), 32'h00F234, "stack address");
        chk(32'({int_sram_sel, wr_n}), 32'h3, "stack internal");
        set_ptr(K_DPTR0, 24'h00F3FF);
        data_chk(K_DPTR0, 24'h00F3FF, 2'h0, 1'b0);
        apb(1'b0, IX_STAT, 8'h00);
        chk(32'(rdat[2:0]), 32'h5, "stack clash");
        apb(1'b1, IX_MCTL, 8'hC0);
        apb(1'b1, IX_ACTL, 8'h06);
        apb(1'b0, IX_ACTL, 8'h00);
        chk(32'(rdat[2]), 32'h0, "stack refused");
        apb(1'b0, IX_STAT, 8'h00);
        chk(32'(rdat[2:0]), 32'h3, "shared status");
        apb(1'b1, IX_STAT, 8'h01);
        apb(1'b1, IX_MCTL, 8'h00);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, IX_ACTL, 8'(m));
            for (int o = 0; o < 3; o++) begin
                @(posedge pclk);
                {op_call_ret, op_inc_first_data_pointer, irq_ack} <= 3'(4 >> o);
                @(posedge pclk);
                {op_call_ret, op_inc_first_data_pointer, irq_ack} <= 3'h0;
                #1;
                chk(32'(extra_cycle), 32'((m == 1 && o != 1) || (m == 2 && o == 1)),
                    "extra cycle");
            end
        end
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, IX_P4CTL, 8'({c[2:0], c[2:0]}));
            repeat (2) @(posedge pclk);
            #1;
            b0 = (c < 4) ? 8'h00 : 8'((2 << (c - 4)) - 1);
            chk(32'(p4_oe), 32'({b0[3:0], b0[3:0]}), "port4 enables");
        end
        complete_run();
    end
endmodule // emap_top_tb
